/* File: design/pbcs_clock_gen.sv */
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// - multiplier zero acts as multiplier one
// - range zero disables pll, forces crystal
// - switch waits three crystal, three vco edges
// - transition output halved to make base clock
// - base clock even duty, source halved
// - no vco select while pll off
// - pll cannot turn off while vco selected
// - pll on and select change in separate writes
// - setup register holds N high, L low
// - manual mode holds interrupt enable at zero
// - manual mode reads flag and lock zero
// - select forced zero if off or range zero
// - setup register read-only while pll on
// - select set forces pll on, read-only
// - integration end drives oscillator enable
// - interrupt output driven by lock detector
// - software picks N from four times bus
// - software picks L from nominal centre
// - lock toggle sets flag, control read clears
// - irq when flag and enable both set
// - select one routes vco, zero crystal
// - reset gives multiplier six, pll on
module pbcs_clock_gen
    import pbcs_pkg::*;
(
    // system
    input  wire logic       clk,
    input  wire logic       rst_b,
    // link to the integration end
    pbcs_if.dev             link,
    // analog side
    input  wire logic       crystal_clock,
    input  wire logic       vco_clock,
    input  wire logic       pll_lock_in,
    input  wire logic       pll_track_in,
    output logic            pll_enable,
    output logic            osc_enable,
    output logic [3:0]      feedback_div,
    output logic [3:0]      vco_range,
    output logic            filter_track
);
    import pbcs_pkg::*;

    function automatic logic rise(input logic now_v, input logic old_v);
        return now_v & ~old_v;
    endfunction

    logic [3:0]  mult_r;
    logic [3:0]  rng_r;
    logic        on_r;
    logic        sel_r;
    logic        ie_r;
    logic        if_r;
    logic        auto_r;
    logic        man_trk_r;
    logic        lock_r;
    logic [7:0]  rdata_r;
    logic        irq_r;
    logic        xq_r;
    logic        xq2_r;
    logic        vq_r;
    logic        vq2_r;
    logic        act_sel_r;
    logic [1:0]  xcnt_r;
    logic [1:0]  vcnt_r;
    logic        base_r;
    pbcs_trans_t st_r;
    logic        en_r;
    logic        osc_r;
    logic [3:0]  div_r;
    logic        trk_r;

    wire wr_ctrl  = link.reg_wr && link.reg_addr == PBCS_IDX_CTRL;
    wire wr_bw    = link.reg_wr && link.reg_addr == PBCS_IDX_BW;
    wire wr_setup = link.reg_wr && link.reg_addr == PBCS_IDX_SETUP;
    wire rd_ctrl  = link.reg_rd && link.reg_addr == PBCS_IDX_CTRL;
    wire w_on     = link.reg_wdata[PBCS_CTRL_ON];
    wire w_sel    = link.reg_wdata[PBCS_CTRL_SEL];
    wire rng_zero = rng_r == 4'h0;

    // pll-on changes only with select clear; select changes only if on
    // stays put in that write
    wire on_chg   = wr_ctrl && !sel_r && (w_on != on_r);
    wire on_nxt   = on_chg ? w_on : on_r;
    wire sel_ok   = on_r && !on_chg && !rng_zero;
    wire sel_wr   = wr_ctrl && (w_sel != sel_r) && (sel_ok || !w_sel);
    wire sel_nxt  = (!on_nxt || rng_zero) ? 1'b0
                  : (sel_wr ? w_sel : sel_r);

    // lock only means anything in automatic mode
    wire lock_now = auto_r & pll_lock_in;
    wire lock_tgl = lock_now != lock_r;
    wire if_nxt   = lock_tgl | (if_r & ~rd_ctrl);

    wire [7:0] ctrl_rd = {ie_r & auto_r, if_r & auto_r,
                          on_r, sel_r, PBCS_CTRL_LOW_RD};
    // lock_r lags auto_r by a cycle, so it is masked again here
    wire [7:0] bw_rd   = {auto_r, lock_r & auto_r,
                          auto_r ? pll_track_in : man_trk_r, 5'h00};
    wire [7:0] setup_rd = {mult_r, rng_r};
    wire [7:0] rd_mux  = (link.reg_addr == PBCS_IDX_CTRL) ? ctrl_rd
                       : (link.reg_addr == PBCS_IDX_BW)   ? bw_rd
                       : (link.reg_addr == PBCS_IDX_SETUP) ? setup_rd
                       : 8'h00;

    wire x_edge   = rise(xq_r, xq2_r);
    wire v_edge   = rise(vq_r, vq2_r);
    wire need_sw  = sel_r != act_sel_r;
    wire sw_done  = xcnt_r == PBCS_TRANS_EDGES &&
                    vcnt_r == PBCS_TRANS_EDGES;
    wire sel_edge = act_sel_r ? v_edge : x_edge;

    // programming, control and bandwidth registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mult_r    <= PBCS_MULT_RST;
            rng_r     <= PBCS_RNG_RST;
            on_r      <= PBCS_ON_RST;
            sel_r     <= 1'b0;
            ie_r      <= 1'b0;
            auto_r    <= 1'b0;
            man_trk_r <= 1'b0;
        end else begin
            if (wr_setup && !on_r) begin
                mult_r <= link.reg_wdata[PBCS_MULT_HI:PBCS_MULT_LO];
                rng_r  <= link.reg_wdata[PBCS_RNG_HI:PBCS_RNG_LO];
            end
            on_r  <= on_nxt;
            sel_r <= sel_nxt;
            if (!auto_r) begin
                ie_r <= 1'b0;
            end else if (wr_ctrl) begin
                ie_r <= link.reg_wdata[PBCS_CTRL_IE];
            end
            if (wr_bw) begin
                auto_r <= link.reg_wdata[PBCS_BW_AUTO];
            end
            // manual value kept aside while automatic mode runs
            if (wr_bw && !auto_r) begin
                man_trk_r <= link.reg_wdata[PBCS_BW_TRK];
            end
        end
    end

    // lock tracking, flag, interrupt and read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_r  <= 1'b0;
            if_r    <= 1'b0;
            irq_r   <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            lock_r <= lock_now;
            if_r   <= if_nxt;
            irq_r  <= if_nxt & ie_r & auto_r;
            if (link.reg_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // source sampling; clocks are slow against clk and taken as levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xq_r  <= 1'b0;
            xq2_r <= 1'b0;
            vq_r  <= 1'b0;
            vq2_r <= 1'b0;
        end else begin
            xq_r  <= crystal_clock;
            xq2_r <= xq_r;
            vq_r  <= vco_clock & en_r;
            vq2_r <= vq_r;
        end
    end

    // transition control: base clock frozen until each source has
    // shown three edges, so no runt reaches the output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= PBCS_RUN;
            act_sel_r <= 1'b0;
            xcnt_r    <= 2'h0;
            vcnt_r    <= 2'h0;
        end else begin
            unique case (st_r)
                PBCS_RUN: begin
                    xcnt_r <= 2'h0;
                    vcnt_r <= 2'h0;
                    if (need_sw) begin
                        st_r <= PBCS_HOLD;
                    end
                end
                PBCS_HOLD: begin
                    if (x_edge && xcnt_r != PBCS_TRANS_EDGES) begin
                        xcnt_r <= xcnt_r + 2'h1;
                    end
                    if (v_edge && vcnt_r != PBCS_TRANS_EDGES) begin
                        vcnt_r <= vcnt_r + 2'h1;
                    end
                    if (sw_done) begin
                        act_sel_r <= sel_r;
                        st_r      <= PBCS_RUN;
                    end
                end
            endcase
        end
    end

    // divide by two of the selected source
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_r <= 1'b0;
        end else if (st_r == PBCS_RUN && sel_edge) begin
            base_r <= ~base_r;
        end
    end

    // analog controls
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r  <= 1'b0;
            osc_r <= 1'b0;
            div_r <= 4'h1;
            trk_r <= 1'b0;
        end else begin
            en_r  <= on_r && !rng_zero && link.oscillator_enable_in;
            osc_r <= link.oscillator_enable_in;
            div_r <= (mult_r == 4'h0) ? 4'h1 : mult_r;
            trk_r <= auto_r ? pll_track_in : man_trk_r;
        end
    end

    assign link.reg_rdata     = rdata_r;
    assign link.base_clock_out = base_r;
    assign link.clock_gen_irq  = irq_r;
    assign pll_enable   = en_r;
    assign osc_enable   = osc_r;
    assign feedback_div = div_r;
    assign vco_range    = rng_r;
    assign filter_track = trk_r;
endmodule

/* File: design/pbcs_pkg.sv */
package pbcs_pkg;
    // device register indices on the register port
    localparam logic [1:0] PBCS_IDX_CTRL  = 2'h0;
    localparam logic [1:0] PBCS_IDX_BW    = 2'h1;
    localparam logic [1:0] PBCS_IDX_SETUP = 2'h2;

    // pll_control_reg fields
    localparam int PBCS_CTRL_IE   = 7;
    localparam int PBCS_CTRL_IF   = 6;
    localparam int PBCS_CTRL_ON   = 5;
    localparam int PBCS_CTRL_SEL  = 4;
    localparam logic [3:0] PBCS_CTRL_LOW_RD = 4'hf;

    // pll_bandwidth_reg fields
    localparam int PBCS_BW_AUTO = 7;
    localparam int PBCS_BW_LOCK = 6;
    localparam int PBCS_BW_TRK  = 5;

    // pll_multiplier_range_setup fields
    localparam int PBCS_MULT_HI = 7;
    localparam int PBCS_MULT_LO = 4;
    localparam int PBCS_RNG_HI  = 3;
    localparam int PBCS_RNG_LO  = 0;

    // reset values
    localparam logic [3:0] PBCS_MULT_RST = 4'h6;
    localparam logic [3:0] PBCS_RNG_RST  = 4'h6;
    localparam logic       PBCS_ON_RST  = 1'b1;
    localparam logic       PBCS_OSC_RST = 1'b1;

    // source edges to wait on a switch of base clock source
    localparam logic [1:0] PBCS_TRANS_EDGES = 2'h3;

    // APB map of the system integration end
    localparam logic [7:0] PBCS_APB_CTRL   = 8'h00;
    localparam logic [7:0] PBCS_APB_BW     = 8'h04;
    localparam logic [7:0] PBCS_APB_SETUP  = 8'h08;
    localparam logic [7:0] PBCS_APB_STATUS = 8'h0c;
    localparam int PBCS_ST_OSC  = 0;
    localparam int PBCS_ST_IRQ  = 1;
    localparam int PBCS_ST_BASE = 2;

    typedef enum logic [1:0] {
        PBCS_RUN  = 2'b01,
        PBCS_HOLD = 2'b10
    } pbcs_trans_t;

    typedef enum logic [2:0] {
        PBCS_IDLE = 3'b001,
        PBCS_ISSUE = 3'b010,
        PBCS_DONE = 3'b100
    } pbcs_apb_t;
endpackage

/* File: design/pbcs_if.sv */
`timescale 1ns/1ps
interface pbcs_if;
    logic [1:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       oscillator_enable_in;
    logic       base_clock_out;
    logic       clock_gen_irq;

    modport dev (
        input  reg_addr, reg_wr, reg_rd, reg_wdata, oscillator_enable_in,
        output reg_rdata, base_clock_out, clock_gen_irq
    );
    modport sys (
        output reg_addr, reg_wr, reg_rd, reg_wdata, oscillator_enable_in,
        input  reg_rdata, base_clock_out, clock_gen_irq
    );
endinterface

/* File: design/pbcs_sys_int.sv */
`timescale 1ns/1ps
module pbcs_sys_int
    import pbcs_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // link to the clock generator
    pbcs_if.sys              link,
    // system side
    output logic             cpu_irq
);
    import pbcs_pkg::*;

    pbcs_apb_t   st_r;
    logic [1:0]  addr_r;
    logic        wr_r;
    logic        rd_r;
    logic [7:0]  wdata_r;
    logic        osc_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;
    logic        base_r;

    wire access  = psel && penable && !pready_r;
    wire is_dev  = paddr == PBCS_APB_CTRL || paddr == PBCS_APB_BW ||
                   paddr == PBCS_APB_SETUP;
    wire is_stat = paddr == PBCS_APB_STATUS;
    wire [1:0] dev_idx = paddr[3:2];
    wire [31:0] stat_rd = {29'h0, base_r, irq_r, osc_r};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= PBCS_IDLE;
            addr_r    <= 2'h0;
            wr_r      <= 1'b0;
            rd_r      <= 1'b0;
            wdata_r   <= 8'h00;
            osc_r     <= PBCS_OSC_RST;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            wr_r      <= 1'b0;
            rd_r      <= 1'b0;
            unique case (st_r)
                PBCS_IDLE: begin
                    if (access && is_dev) begin
                        addr_r  <= dev_idx;
                        wdata_r <= pwdata[7:0];
                        wr_r    <= pwrite;
                        rd_r    <= !pwrite;
                        st_r    <= PBCS_ISSUE;
                    end else if (access) begin
                        pready_r  <= 1'b1;
                        pslverr_r <= !is_stat;
                        prdata_r  <= is_stat ? stat_rd : 32'h0;
                        if (is_stat && pwrite) begin
                            osc_r <= pwdata[PBCS_ST_OSC];
                        end
                    end
                end
                PBCS_ISSUE: begin
                    st_r <= PBCS_DONE;
                end
                PBCS_DONE: begin
                    pready_r <= 1'b1;
                    prdata_r <= {24'h0, link.reg_rdata};
                    st_r     <= PBCS_IDLE;
                end
                default: begin
                    st_r <= PBCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r  <= 1'b0;
            base_r <= 1'b0;
        end else begin
            irq_r  <= link.clock_gen_irq;
            base_r <= link.base_clock_out;
        end
    end

    assign link.reg_addr  = addr_r;
    assign link.reg_wr    = wr_r;
    assign link.reg_rd    = rd_r;
    assign link.reg_wdata = wdata_r;
    assign link.oscillator_enable_in = osc_r;
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign cpu_irq = irq_r;
endmodule

/* File: sim/pbcs_monitor.sv */
`timescale 1ns/1ps
module pbcs_monitor
    import pbcs_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // link signals
    input wire logic [1:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       oscillator_enable_in,
    input wire logic       base_clock_out,
    input wire logic       clock_gen_irq
);
    logic       auto_r;
    logic       base_r;
    logic [6:0] stall_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // bandwidth mode as last written over the link
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_r <= 1'b0;
        end else if (reg_wr && reg_addr == PBCS_IDX_BW) begin
            auto_r <= reg_wdata[PBCS_BW_AUTO];
        end
    end

    // cycles since the base clock last moved, saturating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_r  <= 1'b0;
            stall_r <= 7'h00;
        end else begin
            base_r  <= base_clock_out;
            stall_r <= (base_r != base_clock_out) ? 7'h00 :
                       (stall_r == 7'h7f) ? stall_r : stall_r + 7'h01;
        end
    end

    sequence ctrl_read;
        reg_rd && reg_addr == PBCS_IDX_CTRL;
    endsequence
    sequence bw_read;
        reg_rd && reg_addr == PBCS_IDX_BW;
    endsequence

    a_sel_needs_on: assert property (
        ctrl_read |=> !reg_rdata[PBCS_CTRL_SEL] || reg_rdata[PBCS_CTRL_ON])
        else $error("base select read set with pll off");
    a_off_clears_sel: assert property (
        (ctrl_read ##1 !reg_rdata[PBCS_CTRL_ON]) |-> !reg_rdata[PBCS_CTRL_SEL])
        else $error("pll off but base select reads set");
    a_manual_ie_zero: assert property (
        (ctrl_read ##0 !auto_r) |=> !reg_rdata[PBCS_CTRL_IE])
        else $error("interrupt enable set in manual mode");
    a_manual_flag_zero: assert property (
        (ctrl_read ##0 !auto_r) |=> !reg_rdata[PBCS_CTRL_IF])
        else $error("interrupt flag set in manual mode");
    a_manual_lock_zero: assert property (
        (bw_read ##0 !auto_r) |=> !reg_rdata[PBCS_BW_LOCK])
        else $error("lock reads set in manual mode");
    a_irq_needs_auto: assert property (
        clock_gen_irq |-> auto_r || $past(auto_r))
        else $error("interrupt raised in manual mode");
    a_switch_bounded: assert property (
        stall_r < 7'h50)
        else $error("base clock held static too long");
    a_no_runt_pulse: assert property (
        $changed(base_clock_out) |=> $stable(base_clock_out)[*4])
        else $error("base clock pulse too short");
endmodule

/* File: sim/pll_base_clock_selector_tb.sv */
`timescale 1ns/1ps
module pll_base_clock_selector_tb;
    import pbcs_pkg::*;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, cpu_irq;
    logic        crystal_clock, vco_clock, pll_lock_in, pll_track_in, e;
    logic        pll_enable, osc_enable, filter_track;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  feedback_div, vco_range;
    int          mismatches, tests_run;

    pbcs_if link();
    pbcs_clock_gen i_pbcs_clock_gen (.clk(clk), .rst_b(rst_b), .link(link),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .pll_lock_in(pll_lock_in), .pll_track_in(pll_track_in),
        .pll_enable(pll_enable), .osc_enable(osc_enable),
        .feedback_div(feedback_div), .vco_range(vco_range),
        .filter_track(filter_track));
    pbcs_sys_int i_pbcs_sys_int (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
        .cpu_irq(cpu_irq));
    pbcs_monitor i_pbcs_monitor (.clk(clk), .rst_b(rst_b),
        .reg_addr(link.reg_addr), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .oscillator_enable_in(link.oscillator_enable_in),
        .base_clock_out(link.base_clock_out),
        .clock_gen_irq(link.clock_gen_irq));

    // source edges never coincide with rising clk edges, so sampling is clean
    always #50 clk = ~clk;
    always #400 crystal_clock = ~crystal_clock;
    always #300 vco_clock = ~vco_clock;

    task print_verdict;
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask

    task wait_chg(output int n);
        logic b;
        b = link.base_clock_out;
        n = 0;
        while (link.base_clock_out === b && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            mismatches++;
            print_verdict();
        end
    endtask

    // half period of the base clock in clk cycles, after a switch settles
    task half(input logic [31:0] exp);
        int n;
        repeat (40) @(posedge clk);
        wait_chg(n);
        wait_chg(n);
        chk(32'(n), exp);
    endtask

    task t_reset;
        logic [1:0] seen;
        rdc(PBCS_APB_SETUP, 32'h66);
        rdc(PBCS_APB_CTRL, 32'h2f);
        rdc(PBCS_APB_BW, 32'h00);
        chk(32'(feedback_div), 32'h6);
        chk(32'(osc_enable), 32'h1);
        chk(32'(pll_enable), 32'h1);
        apb(1'b0, 8'h10, 32'h00000000);
        chk(32'(e), 32'h1);
        apb(1'b0, PBCS_APB_STATUS, 32'h00000000);
        // base clock bit runs free, so it is judged by the loop below
        chk(q & 32'hfffffffb, 32'h1);
        seen = 2'h0;
        repeat (6) begin
            apb(1'b0, PBCS_APB_STATUS, 32'h00000000);
            seen[q[PBCS_ST_BASE]] = 1'b1;
        end
        chk(32'(seen), 32'h3);
        wr(PBCS_APB_STATUS, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'(osc_enable), 32'h0);
        chk(32'(pll_enable), 32'h0);
        wr(PBCS_APB_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        chk(32'(pll_enable), 32'h1);
    endtask

    task t_setup;
        wr(PBCS_APB_SETUP, 8'h35);
        rdc(PBCS_APB_SETUP, 32'h66);
        wr(PBCS_APB_CTRL, 8'h0f);
        wr(PBCS_APB_SETUP, 8'h03);
        rdc(PBCS_APB_SETUP, 32'h03);
        chk(32'(pll_enable), 32'h0);
        chk(32'(feedback_div), 32'h1);
        chk(32'(vco_range), 32'h3);
        wr(PBCS_APB_SETUP, 8'h50);
        wr(PBCS_APB_CTRL, 8'h2f);
        wr(PBCS_APB_CTRL, 8'h3f);
        rdc(PBCS_APB_CTRL, 32'h2f);
        chk(32'(pll_enable), 32'h0);
        wr(PBCS_APB_CTRL, 8'h0f);
        // 8 MHz bus on a 4 MHz reference: n is 8, l rounds to 7
        wr(PBCS_APB_SETUP, 8'h87);
        repeat (2) @(posedge clk);
        chk(32'(feedback_div), 32'h8);
        chk(32'(vco_range), 32'h7);
    endtask

    task t_switch;
        wr(PBCS_APB_CTRL, 8'h1f);
        rdc(PBCS_APB_CTRL, 32'h0f);
        wr(PBCS_APB_CTRL, 8'h3f);
        rdc(PBCS_APB_CTRL, 32'h2f);
        half(32'd8);
        wr(PBCS_APB_CTRL, 8'h3f);
        rdc(PBCS_APB_CTRL, 32'h3f);
        half(32'd6);
        wr(PBCS_APB_CTRL, 8'h1f);
        rdc(PBCS_APB_CTRL, 32'h3f);
        wr(PBCS_APB_CTRL, 8'h2f);
        half(32'd8);
    endtask

    task t_irq;
        wr(PBCS_APB_BW, 8'h80);
        wr(PBCS_APB_CTRL, 8'haf);
        rdc(PBCS_APB_CTRL, 32'haf);
        pll_lock_in <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(link.clock_gen_irq), 32'h1);
        chk(32'(cpu_irq), 32'h1);
        rdc(PBCS_APB_BW, 32'hc0);
        rdc(PBCS_APB_CTRL, 32'hef);
        rdc(PBCS_APB_CTRL, 32'haf);
        repeat (2) @(posedge clk);
        chk(32'(link.clock_gen_irq), 32'h0);
        wr(PBCS_APB_CTRL, 8'h2f);
        pll_lock_in <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(link.clock_gen_irq), 32'h0);
        rdc(PBCS_APB_CTRL, 32'h6f);
        wr(PBCS_APB_BW, 8'h00);
        wr(PBCS_APB_CTRL, 8'haf);
        pll_lock_in <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(PBCS_APB_CTRL, 32'h2f);
        rdc(PBCS_APB_BW, 32'h00);
        chk(32'(cpu_irq), 32'h0);
        wr(PBCS_APB_BW, 8'h20);
        rdc(PBCS_APB_BW, 32'h20);
        chk(32'(filter_track), 32'h1);
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        crystal_clock = 1'b0;
        vco_clock = 1'b0;
        pll_lock_in = 1'b0;
        pll_track_in = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_setup;
        t_switch;
        t_irq;
        print_verdict;
    end
endmodule
